/* dv/pmic_config_checker.sv */
// assertions on the configuration block ports
// assumes the base variant and the shortened hold counts set by the bench
`default_nettype none
module pmic_cfg_checker #(
  parameter PB_HOLD_SHORT = 20
) (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       unlock_ok,
  input wire logic       pb_n,
  input wire logic       pgood_raw,
  input wire logic       pgood_out,
  input wire logic       pb_reset_pulse,
  input wire logic       pb_hold_long,
  input wire logic       supervisor_tight_select,
  input wire logic       ov_monitor_en,
  input wire logic [1:0] lockout_threshold_select,
  input wire logic       lockout_hysteresis_select,
  input wire logic [1:0] hv_switch_limit_select,
  input wire logic [1:0] five_volt_switch_limit_select
);
  // --------------------------------
  // properties
  // --------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  cfg_one_wr_a: assert property (
    reg_wr && unlock_ok && reg_addr == 8'h13 |=> pb_hold_long == $past(reg_wdata[7])
    && lockout_threshold_select == $past(reg_wdata[1:0])) else $error("config one lost");
  tight_sel_a: assert property (
    reg_wr && unlock_ok && reg_addr == 8'h13 |=> supervisor_tight_select ==
    $past(reg_wdata[2]) && ov_monitor_en == supervisor_tight_select) else $error("tight");
  cfg_two_wr_a: assert property (
    reg_wr && unlock_ok && reg_addr == 8'h14 |=> hv_switch_limit_select ==
    $past(reg_wdata[3:2]) && five_volt_switch_limit_select == $past(reg_wdata[1:0]))
    else $error("config two lost");
  locked_wr_a: assert property (
    reg_wr && !unlock_ok |=> $stable(hv_switch_limit_select)
    && $stable(lockout_threshold_select)) else $error("locked write took effect");
  hys_fixed_a: assert property (
    lockout_hysteresis_select == 1'b1) else $error("hysteresis not fixed");
  pg_fall_a: assert property (
    $fell(pgood_raw) |-> ##[1:3] !pgood_out) else $error("falling power good held");
  pg_rise_a: assert property (
    $rose(pgood_raw) |=> !pgood_out [*6]) else $error("rising power good early");
  pb_once_a: assert property (
    pb_reset_pulse |=> !pb_reset_pulse) else $error("button pulse too long");
  pb_held_a: assert property (
    pb_reset_pulse |-> !$past(pb_n, PB_HOLD_SHORT - 1)) else $error("button pulse early");
endmodule // pmic_cfg_checker
bind pmic_config_registers pmic_cfg_checker #(.PB_HOLD_SHORT(PB_HOLD_SHORT)) chk (
  .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .unlock_ok(unlock_ok), .pb_n(pb_n), .pgood_raw(pgood_raw),
  .pgood_out(pgood_out), .pb_reset_pulse(pb_reset_pulse), .pb_hold_long(pb_hold_long),
  .supervisor_tight_select(supervisor_tight_select), .ov_monitor_en(ov_monitor_en),
  .lockout_threshold_select(lockout_threshold_select),
  .lockout_hysteresis_select(lockout_hysteresis_select),
  .hv_switch_limit_select(hv_switch_limit_select),
  .five_volt_switch_limit_select(five_volt_switch_limit_select));
`default_nettype wire

/* dv/pmic_host_model.sv */
// host side of the register port: byte writes, byte reads, unlock level
// assumes the bench calls one task at a time from a single process
`default_nettype none
module pmic_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       unlock_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------
  // bus tasks
  // --------------------------------
  // idle and locked at time zero
  initial begin
    {reg_addr, reg_wdata, reg_wr, unlock_ok} = 18'h0;
  end
  // unlock level moves only at an edge
  task automatic set_unlock(input logic v);
    @(posedge ref_clk) unlock_ok <= v;
  endtask
  // one-cycle strobe; data inverted afterwards so a stale byte never looks valid
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // address held, data taken one edge after the register stage
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk) reg_addr <= a;
    @(posedge ref_clk);
    @(posedge ref_clk) d = reg_rdata;
  endtask
endmodule // pmic_host_model
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench for the configuration register block
// assumes the host model and checker are compiled alongside
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, nrst, reg_wr, unlock_ok, pb_n, pgood_raw, pgood_out, pulse, hold;
  logic       tight, ov, warm, hys, l1, l2, l3, x1, x3, o1, e1, o2, e2, o3, e3;
  logic [1:0] thr, hv, fv;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
  int         fail_count, tests_run, n;
  // open-drain wires: pulled up by the far side unless someone drives low
  wire        w1 = !e1 ? o1 : x1;
  wire        w3 = !e3 ? o3 : x3;
  // --------------------------------
  // instances
  // --------------------------------
  pmic_host_model host (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .unlock_ok(unlock_ok));
  // shortened counts: power-good steps of 5, 10, 25, 75 cycles, button 20 and 40
  pmic_config_registers #(.PB_HOLD_SHORT(32'd20), .PB_HOLD_LONG(32'd40),
    .PGOOD_DLY0(32'd5)) DUT (
    .ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .unlock_ok(unlock_ok), .io_one_level(l1),
    .out_two_level(l2), .io_three_level(l3), .pb_n(pb_n), .pgood_raw(pgood_raw),
    .pgood_out(pgood_out), .pb_reset_pulse(pulse), .pb_hold_long(hold),
    .supervisor_tight_select(tight), .ov_monitor_en(ov), .lockout_threshold_select(thr),
    .lockout_hysteresis_select(hys), .hv_switch_limit_select(hv),
    .five_volt_switch_limit_select(fv), .core_warm_reset(warm), .general_io_one_i(w1),
    .general_io_one_o(o1), .general_io_one_oe_n(e1), .general_out_two_o(o2),
    .general_out_two_oe_n(e2), .general_io_three_i(w3), .general_io_three_o(o3),
    .general_io_three_oe_n(e3));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, rd);
    check("read data", rd, exp);
  endtask
  // timing windows allow for the two sync flops and the output stage
  function automatic logic [7:0] win(input int c, input int l);
    return {7'h00, c >= l + 1 && c <= l + 6};
  endfunction
  // bounded wait for the button pulse or the delayed power good
  // sampled on the falling edge, clear of the rising edge that launches them
  task automatic count_to(input bit pb);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((pb ? pulse : pgood_out) !== 1'b1 && n < 400);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // --------------------------------
  // clock, reset, watchdog, tests
  // --------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
  initial begin
    // power good starts low so the design sees one clean low sample first
    {nrst, pb_n, pgood_raw, l1, l2, l3, x1, x3} = 8'h5f;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    reg_check(8'h13, 8'h4c);
    reg_check(8'h14, 8'hc0);
    reg_check(8'h15, 8'h00);
    check("out two", {6'h00, o2, e2}, 8'h02);
    check("tight", {6'h00, tight, ov}, 8'h03);
    check("limits", {2'h0, thr, hv, fv}, 8'h00);
    host.wr_reg(8'h13, 8'h00);
    reg_check(8'h13, 8'h4c);
    host.set_unlock(1'b1);
    host.wr_reg(8'h13, 8'hff);
    host.wr_reg(8'h14, 8'h00);
    reg_check(8'h13, 8'hff);
    check("threshold", {6'h00, thr}, 8'h03);
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(8'h14, {4'hb, c[1:0], c[1:0]});
      reg_check(8'h14, {4'hc, c[1:0], c[1:0]});
      check("limits", {4'h0, hv, fv}, {4'h0, c[1:0], c[1:0]});
      check("hysteresis", {7'h00, hys}, 8'h01);
    end
    // open drain with io one as output, then io one steering out two
    host.wr_reg(8'h13, 8'h0c);
    @(posedge ref_clk) {l1, l2} <= 2'b00;
    repeat (5) @(posedge ref_clk);
    check("io one out", {5'h00, o1, o2, e2 | e1}, 8'h00);
    host.wr_reg(8'h13, 8'h6c);
    @(posedge ref_clk) x1 <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check("io one in", {5'h00, e1, o2, e2}, 8'h04);
    @(posedge ref_clk) x1 <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check("follow", {6'h00, o2, e2}, 8'h02);
    // warm reset role of io three, then plain output
    @(posedge ref_clk) {l3, x3} <= 2'b00;
    repeat (5) @(posedge ref_clk);
    check("warm", {6'h00, warm, e3}, 8'h03);
    host.wr_reg(8'h14, 8'h00);
    repeat (5) @(posedge ref_clk);
    check("gp out", {5'h00, o3, warm, e3}, 8'h00);
    for (int c = 0; c < 4; c++) begin
      host.wr_reg(8'h13, {3'b010, c[1:0], 3'b100});
      @(posedge ref_clk) pgood_raw <= 1'b1;
      count_to(1'b0);
      check("pgood delay", win(n, c == 3 ? 75 : (c == 2 ? 25 : (c + 1) * 5)), 8'h01);
      @(posedge ref_clk) pgood_raw <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("pgood fall", {7'h00, pgood_out}, 8'h00);
    end
    for (int b = 0; b < 2; b++) begin
      host.wr_reg(8'h13, {b[0], 7'h4c});
      @(posedge ref_clk) pb_n <= 1'b0;
      count_to(1'b1);
      check("hold time", win(n, b ? 40 : 20), 8'h01);
      check("hold select", {7'h00, hold}, {7'h00, b[0]});
      @(posedge ref_clk) pb_n <= 1'b1;
    end
    give_verdict();
  end
endmodule // testbench
`default_nettype wire

/* hw/pmic_config_map.vh */
// constants for the two configuration registers: offsets, resets, fields, timings
// assumes it is included by bare name from the register block source
`ifndef PMIC_CONFIG_MAP_VH
`define PMIC_CONFIG_MAP_VH

// ----------------------------------------------------------------
// register offsets and reset values
// ----------------------------------------------------------------
`define CONFIG_ONE_ADDR      8'h13
`define CONFIG_TWO_ADDR      8'h14
`define CONFIG_ONE_RESET     8'h4c
`define CONFIG_TWO_RESET     8'hc0
`define CONFIG_TWO_RESET_ALT 8'h80
`define CONFIG_TWO_RO_MASK   8'h30
`define READ_UNMAPPED        8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PB_HOLD_BIT          7
`define OUT_TWO_DRIVE_BIT    6
`define IO_ONE_ROLE_BIT      5
`define PGOOD_DLY_HI         4
`define PGOOD_DLY_LO         3
`define SUP_TIGHT_BIT        2
`define LOCKOUT_THR_HI       1
`define LOCKOUT_THR_LO       0
`define WARM_RST_EN_BIT      7
`define LOCKOUT_HYS_BIT      6
`define HV_LIMIT_HI          3
`define HV_LIMIT_LO          2
`define FIVE_V_LIMIT_HI      1
`define FIVE_V_LIMIT_LO      0

// ----------------------------------------------------------------
// timing: figures in their own unit, then cycles at the core clock
// ----------------------------------------------------------------
`define CLK_HZ               40000000
`define PB_HOLD_SHORT_S      8
`define PB_HOLD_LONG_S       15
`define PGOOD_DLY0_MS        10
`define PGOOD_DLY1_MS        20
`define PGOOD_DLY2_MS        50
`define PGOOD_DLY3_MS        150
`define SEC_CYC(s)           ((s) * `CLK_HZ)
`define MS_CYC(m)            ((m) * (`CLK_HZ / 1000))

`endif

/* hw/pmic_config_registers.v */
// two configuration registers of the power-management core and the logic they steer
// assumes a same-clock register port from the serial management unit, an unlock
// level from the password unit, and raw pins that it takes through two-flop synchronisers of its own
`include "pmic_config_map.vh"
`default_nettype none

module pmic_config_registers #(
  parameter        ALT_VARIANT     = 0,
  parameter [31:0] PB_HOLD_SHORT   = `SEC_CYC(`PB_HOLD_SHORT_S),
  parameter [31:0] PB_HOLD_LONG    = `SEC_CYC(`PB_HOLD_LONG_S),
  parameter [31:0] PGOOD_DLY0      = `MS_CYC(`PGOOD_DLY0_MS),
  // longer delays scale from the shortest, so one override keeps all four in step
  parameter [31:0] PGOOD_DLY1      = PGOOD_DLY0 * `PGOOD_DLY1_MS / `PGOOD_DLY0_MS,
  parameter [31:0] PGOOD_DLY2      = PGOOD_DLY0 * `PGOOD_DLY2_MS / `PGOOD_DLY0_MS,
  parameter [31:0] PGOOD_DLY3      = PGOOD_DLY0 * `PGOOD_DLY3_MS / `PGOOD_DLY0_MS
) (
  input  wire       ref_clk,
  input  wire       nrst,
  // register port from the serial management unit
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  output wire [7:0] reg_rdata,
  input  wire       unlock_ok,
  // enable-register output levels, 1 releases the pin, except out two in push-pull, where 1 drives it high
  input  wire       io_one_level,
  input  wire       out_two_level,
  input  wire       io_three_level,
  // analog and sequencer side
  input  wire       pb_n,
  input  wire       pgood_raw,
  output wire       pgood_out,
  output wire       pb_reset_pulse,
  output wire       pb_hold_long,
  output wire       supervisor_tight_select,
  output wire       ov_monitor_en,
  output wire [1:0] lockout_threshold_select,
  output wire       lockout_hysteresis_select,
  output wire [1:0] hv_switch_limit_select,
  output wire [1:0] five_volt_switch_limit_select,
  output wire       core_warm_reset,
  // general_io_one, open drain
  input  wire       general_io_one_i,
  output wire       general_io_one_o,
  output wire       general_io_one_oe_n,
  // general_out_two
  output wire       general_out_two_o,
  output wire       general_out_two_oe_n,
  // general_io_three, open drain
  input  wire       general_io_three_i,
  output wire       general_io_three_o,
  output wire       general_io_three_oe_n
);

  // ----------------------------------------------------------------
  // reset value of config_two depends on the variant
  // ----------------------------------------------------------------
  localparam [7:0] CFG_TWO_RST = (ALT_VARIANT != 0) ? `CONFIG_TWO_RESET_ALT
                                                    : `CONFIG_TWO_RESET;

  reg  [7:0]  config_one_r;
  reg  [7:0]  config_two_r;
  reg  [7:0]  config_two_nxt;
  reg  [7:0]  rdata_r;

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  wire wr_one = reg_wr & unlock_ok & (reg_addr == `CONFIG_ONE_ADDR);
  wire wr_two = reg_wr & unlock_ok & (reg_addr == `CONFIG_TWO_ADDR);

  // reserved bits never take a write; base variant keeps 400 mV fixed
  always @* begin
    config_two_nxt = reg_wdata & ~`CONFIG_TWO_RO_MASK;
    if (ALT_VARIANT == 0) begin
      config_two_nxt[`LOCKOUT_HYS_BIT] = 1'b1;
    end
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      config_one_r <= `CONFIG_ONE_RESET;
      config_two_r <= CFG_TWO_RST;
    end else begin
      if (wr_one) begin
        config_one_r <= reg_wdata;
      end
      if (wr_two) begin
        config_two_r <= config_two_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  // read data is registered, one cycle behind the address
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= `READ_UNMAPPED;
    end else begin
      case (reg_addr)
        `CONFIG_ONE_ADDR: rdata_r <= config_one_r;
        `CONFIG_TWO_ADDR: rdata_r <= config_two_r;
        default:          rdata_r <= `READ_UNMAPPED;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire io_one_as_input = config_one_r[`IO_ONE_ROLE_BIT];
  wire push_pull       = config_one_r[`OUT_TWO_DRIVE_BIT];
  wire warm_rst_en     = config_two_r[`WARM_RST_EN_BIT];
  wire [1:0] pgd_sel   = config_one_r[`PGOOD_DLY_HI:`PGOOD_DLY_LO];

  assign pb_hold_long                  = config_one_r[`PB_HOLD_BIT];
  assign supervisor_tight_select       = config_one_r[`SUP_TIGHT_BIT];
  assign ov_monitor_en                 = config_one_r[`SUP_TIGHT_BIT];
  assign lockout_threshold_select      = config_one_r[`LOCKOUT_THR_HI:`LOCKOUT_THR_LO];
  assign lockout_hysteresis_select     = config_two_r[`LOCKOUT_HYS_BIT];
  assign hv_switch_limit_select        = config_two_r[`HV_LIMIT_HI:`HV_LIMIT_LO];
  assign five_volt_switch_limit_select = config_two_r[`FIVE_V_LIMIT_HI:`FIVE_V_LIMIT_LO];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // order: pgood, push button, io one, io three
  reg  [3:0] meta_r;
  reg  [3:0] sync_r;

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 4'hf;
      sync_r <= 4'hf;
    end else begin
      meta_r <= {general_io_three_i, general_io_one_i, pb_n, pgood_raw};
      sync_r <= meta_r;
    end
  end

  reg pgood_seen_r;

  // pgood stage is gated low by pgood_seen_r until a low sample, so no false good at start
  wire pgood_s    = sync_r[0] & pgood_seen_r;
  wire pb_n_s     = sync_r[1];
  wire io_one_s   = sync_r[2];
  wire io_three_s = sync_r[3];

  // the synchroniser resets high; wait one clean sample before trusting pgood
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pgood_seen_r <= 1'b0;
    end else if (!sync_r[0]) begin
      pgood_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // power-good delay
  // ----------------------------------------------------------------
  localparam PG_LOW  = 2'h0;
  localparam PG_WAIT = 2'h1;
  localparam PG_HIGH = 2'h2;

  reg  [1:0]  pg_state_r;
  reg  [1:0]  pg_state_nxt;
  reg  [31:0] pg_cnt_r;
  reg  [31:0] pg_cnt_nxt;
  reg  [31:0] pg_limit;

  // delay code is read live, so a change during the wait takes effect at once
  always @* begin
    case (pgd_sel)
      2'h0:    pg_limit = PGOOD_DLY0;
      2'h1:    pg_limit = PGOOD_DLY1;
      2'h2:    pg_limit = PGOOD_DLY2;
      default: pg_limit = PGOOD_DLY3;
    endcase
  end

  always @* begin
    pg_state_nxt = pg_state_r;
    pg_cnt_nxt   = pg_cnt_r;
    case (pg_state_r)
      PG_LOW: begin
        pg_cnt_nxt = 32'h0000_0000;
        if (pgood_s) begin
          pg_state_nxt = PG_WAIT;
        end
      end
      PG_WAIT: begin
        if (!pgood_s) begin
          pg_state_nxt = PG_LOW;
        end else if (pg_cnt_r >= pg_limit - 32'h0000_0001) begin
          pg_state_nxt = PG_HIGH;
        end else begin
          pg_cnt_nxt = pg_cnt_r + 32'h0000_0001;
        end
      end
      PG_HIGH: begin
        if (!pgood_s) begin
          pg_state_nxt = PG_LOW;
        end
      end
      default: begin
        pg_state_nxt = PG_LOW;
      end
    endcase
  end

  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pg_state_r <= PG_LOW;
      pg_cnt_r   <= 32'h0000_0000;
    end else begin
      pg_state_r <= pg_state_nxt;
      pg_cnt_r   <= pg_cnt_nxt;
    end
  end

  // falling edge reaches the output the cycle the sample drops
  assign pgood_out = (pg_state_r == PG_HIGH) & pgood_s;

  // ----------------------------------------------------------------
  // push-button hold timer
  // ----------------------------------------------------------------
  reg  [31:0] pb_cnt_r;
  reg         pb_fired_r;
  reg         pb_pulse_r;

  wire [31:0] pb_limit = pb_hold_long ? PB_HOLD_LONG : PB_HOLD_SHORT;

  // one pulse per press; the button must be released before the next one
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pb_cnt_r   <= 32'h0000_0000;
      pb_fired_r <= 1'b0;
      pb_pulse_r <= 1'b0;
    end else begin
      pb_pulse_r <= 1'b0;
      if (pb_n_s) begin
        pb_cnt_r   <= 32'h0000_0000;
        pb_fired_r <= 1'b0;
      end else if (!pb_fired_r) begin
        if (pb_cnt_r >= pb_limit - 32'h0000_0001) begin
          pb_fired_r <= 1'b1;
          pb_pulse_r <= 1'b1;
        end else begin
          pb_cnt_r <= pb_cnt_r + 32'h0000_0001;
        end
      end
    end
  end

  assign pb_reset_pulse = pb_pulse_r;

  // ----------------------------------------------------------------
  // general pins
  // ----------------------------------------------------------------
  reg out_two_level_r;
  reg io_one_rel_r;
  reg io_three_rel_r;
  reg warm_rst_r;

  // as an input, io one hands its level to out two; otherwise the enable bits rule
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      out_two_level_r <= 1'b1;
      io_one_rel_r    <= 1'b1;
      io_three_rel_r  <= 1'b1;
      warm_rst_r      <= 1'b0;
    end else begin
      if (io_one_as_input) begin
        out_two_level_r <= io_one_s;
        io_one_rel_r    <= 1'b1;
      end else begin
        out_two_level_r <= out_two_level;
        io_one_rel_r    <= io_one_level;
      end
      io_three_rel_r <= warm_rst_en | io_three_level;
      warm_rst_r     <= warm_rst_en & ~io_three_s;
    end
  end

  // io one: only ever pulls low
  assign general_io_one_o    = 1'b0;
  assign general_io_one_oe_n = io_one_rel_r;

  // out two: push-pull drives both levels, open drain only the low one
  assign general_out_two_o    = out_two_level_r & push_pull;
  assign general_out_two_oe_n = out_two_level_r & ~push_pull;

  // io three: released whenever it serves as the warm-reset input
  assign general_io_three_o    = 1'b0;
  assign general_io_three_oe_n = io_three_rel_r;

  // with warm_rst_en set, low on the pin asserts reset of both core bucks
  assign core_warm_reset = warm_rst_r;

endmodule // pmic_config_registers

`default_nettype wire
